// ### hw/dcc_params.svh
// Constants for the DAC code correction and load block
`ifndef DCC_PARAMS_SVH
`define DCC_PARAMS_SVH
`define DCC_ADDR_CODE 7'h01
`define DCC_ADDR_GAIN 7'h02
`define DCC_ADDR_OFFSET 7'h03
`define DCC_ADDR_STATUS 7'h04
`define DCC_BUSY_BIT 0
`define DCC_CODE_MAX 18'h1ffff
`define DCC_CODE_MIN 18'h20000
`define DCC_GAIN_RST 18'h3ffff
`define DCC_CALC_NS 2500
`define DCC_CLK_NS 10
`define DCC_CALC_CYC (`DCC_CALC_NS / `DCC_CLK_NS)
`define DCC_PIPE_CYC 4
`endif

// ### hw/dcc_pkg.sv
// Types shared by the DAC code correction block
package dcc_pkg;
  typedef struct packed {
    logic [6:0] addr;
    logic rd;
    logic [23:0] payload;
  } dcc_frame_t;
  typedef struct packed {
    logic [17:0] code;
    logic [17:0] gain;
    logic [17:0] offset;
  } dcc_coef_t;
endpackage

// ### hw/dcc_spi_frame.sv
// Serial frame shifter: 32-bit address, direction and payload frames
`timescale 1ns/10ps
module dcc_spi_frame
  import dcc_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic sclk_in,
  input wire logic cs_n_in,
  input wire logic mosi_in,
  input wire logic [23:0] rd_data_in,
  output logic miso_out,
  output logic frame_valid_out,
  output dcc_frame_t frame_out
);
  logic sclk_d_r;
  logic [5:0] cnt_r;
  logic [31:0] sh_r;
  logic [23:0] tx_r;
  logic rise;
  logic fall;
  assign rise = sclk_in & ~sclk_d_r;
  assign fall = ~sclk_in & sclk_d_r;
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      sclk_d_r <= 1'b0;
    end else begin
      sclk_d_r <= sclk_in;
    end
  end
  // Frame boundary: seven address bits, direction, then 24 payload bits
  always_ff @(posedge clk_in) begin
    if (!rst_n_in || cs_n_in) begin
      cnt_r <= 6'h00;
      sh_r <= 32'h0;
    end else if (rise) begin
      sh_r <= {sh_r[30:0], mosi_in}; // R12
      cnt_r <= (cnt_r == 6'h20) ? cnt_r : cnt_r + 6'h01;
    end
  end
  // Write frames take effect at the end of the transaction, not mid-frame
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      frame_valid_out <= 1'b0;
      frame_out <= '0;
    end else begin
      frame_valid_out <= cs_n_in & (cnt_r == 6'h20);
      if (cs_n_in && cnt_r == 6'h20) begin
        frame_out <= sh_r; // R12
      end else if (!cs_n_in && cnt_r == 6'h08) begin
        // Address is exposed early so a read returns the register it names
        frame_out.addr <= sh_r[7:1]; // R12
      end
    end
  end
  // Read data shifts out on falling edges once the direction bit is in
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      tx_r <= 24'h0;
      miso_out <= 1'b0;
    end else if (cs_n_in) begin
      miso_out <= 1'b0;
    end else if (fall && cnt_r == 6'h08) begin
      tx_r <= {rd_data_in[22:0], 1'b0};
      miso_out <= rd_data_in[23];
    end else if (fall && cnt_r > 6'h08) begin
      tx_r <= {tx_r[22:0], 1'b0};
      miso_out <= tx_r[23];
    end
  end
endmodule

// ### hw/dcc_corr_calc.sv
// Multi-cycle gain and offset correction with saturation
`timescale 1ns/10ps
`include "dcc_params.svh"
module dcc_corr_calc
  import dcc_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic start_in,
  input wire dcc_coef_t coef_in,
  output logic done_out,
  output logic [17:0] result_out
);
  logic [2:0] stage_r;
  logic signed [37:0] prod_r;
  logic signed [38:0] sum_r;
  logic signed [17:0] code_s;
  logic signed [19:0] gain_s;
  logic signed [38:0] off_s;
  assign code_s = coef_in.code; // R1
  assign gain_s = {1'b0, coef_in.gain} + 20'sh00001; // R2
  assign off_s = {{3{coef_in.offset[17]}}, coef_in.offset, 18'h0}; // R3
  // Pipeline is restarted by a new start even when mid-flight
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      stage_r <= 3'h0;
    end else if (start_in) begin
      stage_r <= 3'h1;
    end else if (stage_r != 3'h0) begin
      stage_r <= (stage_r == 3'(`DCC_PIPE_CYC)) ? 3'h0 : stage_r + 3'h1; // R11
    end
  end
  // Sum at 2^-18 scale: code*(gain+1) plus offset<<18, result keeps bits 35:18
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      prod_r <= '0;
      sum_r <= '0;
      result_out <= 18'h0;
    end else begin
      if (stage_r == 3'h1) begin
        prod_r <= 38'(code_s * gain_s); // R4
      end
      if (stage_r == 3'h2) begin
        sum_r <= 39'(prod_r) + off_s; // R4
      end
      if (stage_r == 3'h3) begin
        if (sum_r > 39'sh0007ffffffff) begin
          result_out <= `DCC_CODE_MAX; // R5
        end else if (sum_r < -39'sh000800000000) begin
          result_out <= `DCC_CODE_MIN; // R5
        end else begin
          result_out <= sum_r[35:18];
        end
      end
    end
  end
  assign done_out = (stage_r == 3'(`DCC_PIPE_CYC));
endmodule

// ### hw/dcc_top.sv
// DAC code correction registers, busy status and load latch control
`timescale 1ns/10ps
`include "dcc_params.svh"
// Operation
// [R1] Output data code is signed two's complement, 18 bits.
// [R2] Gain multiplier is (coefficient + 1) / 2^18, unsigned.
// [R3] Offset coefficient is signed 18-bit, about half-scale range.
// [R4] Result equals code times gain plus offset, scaled as documented.
// [R5] Overflow clips to max code, underflow to min code.
// [R6] Positive-only mode saturates identically; shift applied after, outside logic.
// [R7] Writing code, gain or offset recalculates; load low updates output after.
// [R8] Falling load edge after a write updates output even if pin rises.
// [R9] With load held high, output updates at falling edge after completion.
// [R10] Busy status reads high during calculation, low once done.
// [R11] Calculation finishes within 2.5 us of the writing transaction.
// [R12] Serial access: 7-bit address, direction bit, 24-bit payload.
// [R13] Each recalculation uses latest stored data, gain and offset.
module dcc_top
  import dcc_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic sclk_in,
  input wire logic cs_n_in,
  input wire logic mosi_in,
  input wire logic load_latch_pin_in,
  input wire logic pos_only_mode_in,
  output logic miso_out,
  output logic [17:0] dac_code_out,
  output logic dac_pos_shift_out,
  output logic dac_update_out
);
  // ****************************************
  // Serial access
  // ****************************************
  dcc_frame_t frame;
  logic frame_valid;
  logic [23:0] rd_data;
  dcc_spi_frame u_frame (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .sclk_in(sclk_in),
    .cs_n_in(cs_n_in),
    .mosi_in(mosi_in),
    .rd_data_in(rd_data),
    .miso_out(miso_out),
    .frame_valid_out(frame_valid),
    .frame_out(frame)
  );

  // ****************************************
  // Correction registers
  // ****************************************
  dcc_coef_t coef_r;
  logic wr_hit;
  logic busy_r;
  logic pending_r;
  logic load_latch_pin_d_r;
  logic calc_done;
  logic [17:0] calc_result;
  logic load_latch_pin_fall;
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      coef_r.code <= 18'h0;
      coef_r.gain <= `DCC_GAIN_RST;
      coef_r.offset <= 18'h0;
    end else if (frame_valid && !frame.rd) begin
      if (frame.addr == `DCC_ADDR_CODE) begin
        coef_r.code <= frame.payload[17:0];
      end else if (frame.addr == `DCC_ADDR_GAIN) begin
        coef_r.gain <= frame.payload[17:0];
      end else if (frame.addr == `DCC_ADDR_OFFSET) begin
        coef_r.offset <= frame.payload[17:0];
      end
    end
  end
  always_comb begin
    wr_hit = frame_valid && !frame.rd && (frame.addr == `DCC_ADDR_CODE ||
      frame.addr == `DCC_ADDR_GAIN || frame.addr == `DCC_ADDR_OFFSET); // R7
  end
  always_comb begin
    rd_data = 24'h0;
    if (frame.addr == `DCC_ADDR_CODE) begin
      rd_data = {6'h00, coef_r.code};
    end else if (frame.addr == `DCC_ADDR_GAIN) begin
      rd_data = {6'h00, coef_r.gain};
    end else if (frame.addr == `DCC_ADDR_OFFSET) begin
      rd_data = {6'h00, coef_r.offset};
    end else if (frame.addr == `DCC_ADDR_STATUS) begin
      rd_data[`DCC_BUSY_BIT] = busy_r; // R10
    end
  end
  // ****************************************
  // Calculation engine
  // ****************************************
  logic start_r;
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      start_r <= 1'b0;
    end else begin
      start_r <= wr_hit; // R13
    end
  end
  dcc_corr_calc u_calc (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .start_in(start_r),
    .coef_in(coef_r),
    .done_out(calc_done),
    .result_out(calc_result)
  );
  // Busy spans the write until the engine finishes; a new write mid-flight extends it
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      busy_r <= 1'b0;
    end else if (wr_hit || start_r) begin
      busy_r <= 1'b1; // R10
    end else if (calc_done) begin
      busy_r <= 1'b0; // R10
    end
  end

  // ****************************************
  // Load latch
  // ****************************************
  assign load_latch_pin_fall = load_latch_pin_d_r & ~load_latch_pin_in;
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      // Starts low so a pin idling low shows no false fall after reset
      load_latch_pin_d_r <= 1'b0;
    end else begin
      load_latch_pin_d_r <= load_latch_pin_in;
    end
  end
  // A fall during the calculation is remembered so the result still goes out
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      pending_r <= 1'b0;
    end else if (calc_done) begin
      pending_r <= 1'b0;
    end else if (load_latch_pin_fall && (busy_r || wr_hit)) begin
      // A fall in the very cycle of a write still waits for the new result
      pending_r <= 1'b1; // R8
    end
  end
  logic upd_nxt;
  always_comb begin
    upd_nxt = 1'b0;
    if (calc_done && (!load_latch_pin_in || pending_r || load_latch_pin_fall)) begin
      upd_nxt = 1'b1; // R7 R8
    end else if (load_latch_pin_fall && !busy_r && !wr_hit) begin
      upd_nxt = 1'b1; // R9
    end
  end
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      dac_code_out <= 18'h0;
      dac_update_out <= 1'b0;
      dac_pos_shift_out <= 1'b0;
    end else begin
      dac_update_out <= upd_nxt;
      dac_pos_shift_out <= pos_only_mode_in; // R6
      if (upd_nxt) begin
        dac_code_out <= calc_result; // R1
      end
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  localparam int CALC_LIM = `DCC_CALC_CYC;
  sequence s_write;
    wr_hit;
  endsequence
  sequence s_idle_done;
    !busy_r [*2];
  endsequence
  chk_write_sets_busy: assert property (@(posedge clk_in) disable iff (!rst_n_in) // R10
    s_write |=> busy_r) else $error("busy not raised after write");
  chk_calc_bound: assert property (@(posedge clk_in) disable iff (!rst_n_in) // R11
    s_write |-> ##[1:CALC_LIM] !busy_r) else $error("calculation exceeded bound");
  chk_auto_update: assert property (@(posedge clk_in) disable iff (!rst_n_in) // R7
    (calc_done && !load_latch_pin_in) |=> dac_update_out) else $error("no auto update");
  chk_fall_idle: assert property (@(posedge clk_in) disable iff (!rst_n_in) // R9
    (load_latch_pin_fall && !busy_r && !wr_hit) |=> dac_update_out && dac_code_out == $past(calc_result))
    else $error("falling edge did not update");
  chk_pending_kept: assert property (@(posedge clk_in) disable iff (!rst_n_in) // R8
    (load_latch_pin_fall && (busy_r || wr_hit) && !calc_done) |=> pending_r) else $error("fall lost");
  chk_sat_high: assert property (@(posedge clk_in) disable iff (!rst_n_in) // R5
    (u_calc.stage_r == 3'h3 && u_calc.sum_r > 39'sh0007ffffffff)
    |=> calc_result == `DCC_CODE_MAX) else $error("no positive clip");
  chk_sat_low: assert property (@(posedge clk_in) disable iff (!rst_n_in) // R5
    (u_calc.stage_r == 3'h3 && u_calc.sum_r < -39'sh000800000000)
    |=> calc_result == `DCC_CODE_MIN) else $error("no negative clip");
  chk_idle_quiet: assert property (@(posedge clk_in) disable iff (!rst_n_in) // R10
    s_idle_done |-> !calc_done) else $error("done while idle");
  chk_start_follows: assert property (@(posedge clk_in) disable iff (!rst_n_in) // R13
    s_write |=> start_r ##4 calc_done) else $error("engine not started");
  chk_shift_mode: assert property (@(posedge clk_in) disable iff (!rst_n_in) // R6
    ##1 dac_pos_shift_out == $past(pos_only_mode_in)) else $error("shift mismatch");
endmodule

// ### tb/dcc_host_model.sv
// Host model: serial register frames and load latch pin
`timescale 1ns/10ps
module dcc_host_model (
  input wire logic clk_in,
  input wire logic miso_in,
  output logic sclk_out,
  output logic cs_n_out,
  output logic mosi_out,
  output logic load_latch_pin_out
);
  initial begin
    sclk_out = 1'b0;
    cs_n_out = 1'b1;
    mosi_out = 1'b0;
    load_latch_pin_out = 1'b0;
  end
  task automatic wait_clk(input int n);
    repeat (n) @(negedge clk_in);
  endtask
  // Serial clock stands still outside frames; 8 system clocks per bit
  task automatic xfer(input logic [6:0] a, input logic rd, input logic [23:0] d,
                      output logic [23:0] q);
    logic [31:0] f;
    f = {a, rd, d};
    q = 24'h0;
    wait_clk(1);
    cs_n_out = 1'b0;
    for (int i = 0; i < 32; i++) begin
      mosi_out = f[31-i];
      wait_clk(4);
      if (i >= 8) q = {q[22:0], miso_in};
      sclk_out = 1'b1;
      wait_clk(4);
      sclk_out = 1'b0;
    end
    wait_clk(4);
    cs_n_out = 1'b1;
    mosi_out = ~mosi_out; // Released line must not keep the last bit
    wait_clk(4);
  endtask
  task automatic set_load(input logic v);
    wait_clk(1);
    load_latch_pin_out = v;
  endtask
endmodule

// ### tb/tb_dcc_top.sv
// Self-checking bench for the DAC code correction block
`timescale 1ns/10ps
`include "dcc_params.svh"
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin n_errors++; \
  $display("unexpected at %0t: got %h expected %h", $time, a, b); end end
module tb_dcc_top;
  logic clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic pos_only_mode_in = 1'b0;
  logic sclk, cs_n, mosi, load, miso, pos_shift, upd;
  logic [17:0] code_out;
  logic [18:0] exp_q[$];
  logic [18:0] e;
  logic [17:0] c_r = 18'h0;
  logic [17:0] g_r = `DCC_GAIN_RST;
  logic [17:0] o_r = 18'h0;
  logic [23:0] q;
  logic [17:0] codes[4] = '{18'h00000, 18'h20000, 18'h1ffff, 18'h3ffff};
  int n_errors = 0;
  int checks_done = 0;
  int cycles = 0;
  int seed = 32'h069d;
  always #5 clk_in = ~clk_in;
  dcc_host_model u_host (.clk_in(clk_in), .miso_in(miso), .sclk_out(sclk), .cs_n_out(cs_n),
    .mosi_out(mosi), .load_latch_pin_out(load));
  dcc_top u_dut (.clk_in(clk_in), .rst_n_in(rst_n_in), .sclk_in(sclk), .cs_n_in(cs_n),
    .mosi_in(mosi), .load_latch_pin_in(load), .pos_only_mode_in(pos_only_mode_in),
    .miso_out(miso), .dac_code_out(code_out), .dac_pos_shift_out(pos_shift),
    .dac_update_out(upd));
  // Floor of the scaled sum, then clip instead of wrapping
  function automatic logic [17:0] exp_code(logic [17:0] c, logic [17:0] g, logic [17:0] o);
    longint p;
    p = (longint'($signed(c)) * (longint'(g) + 1) + (longint'($signed(o)) <<< 18)) >>> 18;
    if (p > 131071) return `DCC_CODE_MAX;
    if (p < -131072) return `DCC_CODE_MIN;
    return p[17:0];
  endfunction
  task automatic give_verdict();
    if (n_errors == 0 && checks_done > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic wr(input logic [6:0] a, input logic [17:0] v, input logic push);
    logic [23:0] d;
    d = 24'($random(seed));
    d[17:0] = v;
    if (a == `DCC_ADDR_CODE) c_r = v;
    if (a == `DCC_ADDR_GAIN) g_r = v;
    if (a == `DCC_ADDR_OFFSET) o_r = v;
    if (push) exp_q.push_back({pos_only_mode_in, exp_code(c_r, g_r, o_r)});
    u_host.xfer(a, 1'b0, d, q);
  endtask
  // ****************************************
  // Result watcher
  // ****************************************
  always @(negedge clk_in) begin
    cycles++;
    if (cycles == 20000) begin
      n_errors++;
      give_verdict();
    end
    if (upd === 1'b1) begin
      if (exp_q.size() == 0) `CHK(upd, 1'b0)
      else begin
        e = exp_q.pop_front();
        `CHK({pos_shift, code_out}, e)
      end
    end
  end
  initial begin
    repeat (20) @(negedge clk_in);
    rst_n_in = 1'b1;
    foreach (codes[i]) wr(`DCC_ADDR_CODE, codes[i], 1'b1);
    for (int i = 0; i < 12; i++) begin
      // Let the previous update land before the mode flips
      repeat (4) @(negedge clk_in);
      pos_only_mode_in = i[0];
      wr(`DCC_ADDR_GAIN, 18'($random(seed)), 1'b1);
      wr(`DCC_ADDR_OFFSET, 18'($random(seed)), 1'b1);
      wr(`DCC_ADDR_CODE, 18'($random(seed)), 1'b1);
    end
    wr(`DCC_ADDR_GAIN, 18'h3ffff, 1'b1);
    wr(`DCC_ADDR_OFFSET, 18'h1ffff, 1'b1);
    wr(`DCC_ADDR_CODE, 18'h1ffff, 1'b1);
    wr(`DCC_ADDR_OFFSET, 18'h20000, 1'b1);
    wr(`DCC_ADDR_CODE, 18'h20000, 1'b1);
    // Writes to the status place or an unmapped place must not recalculate
    wr(`DCC_ADDR_STATUS, 18'h3ffff, 1'b0);
    wr(7'h7f, 18'h12345, 1'b0);
    // Each read must return the register named in its own frame
    u_host.xfer(`DCC_ADDR_STATUS, 1'b1, 24'h0, q);
    `CHK(q[`DCC_BUSY_BIT], 1'b0)
    u_host.xfer(`DCC_ADDR_CODE, 1'b1, 24'h0, q);
    `CHK(q, {6'h0, c_r})
    u_host.set_load(1'b1);
    wr(`DCC_ADDR_CODE, 18'h0abcd, 1'b0);
    repeat (`DCC_CALC_CYC) @(negedge clk_in);
    `CHK(exp_q.size() == 0, 1'b1)
    exp_q.push_back({pos_only_mode_in, exp_code(c_r, g_r, o_r)});
    u_host.set_load(1'b0);
    repeat (3) @(negedge clk_in);
    `CHK(exp_q.size() == 0, 1'b1)
    u_host.set_load(1'b1);
    wr(`DCC_ADDR_CODE, 18'h15555, 1'b1);
    u_host.set_load(1'b0);
    u_host.set_load(1'b1);
    repeat (20) @(negedge clk_in);
    `CHK(exp_q.size() == 0, 1'b1)
    exp_q.push_back({pos_only_mode_in, exp_code(c_r, g_r, o_r)});
    u_host.set_load(1'b0);
    repeat (10) @(negedge clk_in);
    `CHK(exp_q.size() == 0, 1'b1)
    give_verdict();
  end
endmodule
